// ===== bench/tlsa_partner.sv
/*
  Remote partner: link pulses, crossings, pages.
  Assumes hclk; the bench starts packets and pages.
*/
`timescale 1ns/1ps
module tlsa_partner (
  input  wire logic        hclk,
  input  wire logic        lp_on,
  input  wire logic        lp_inv,
  output logic             sq_pos_cross,
  output logic             sq_neg_cross,
  output logic             eop_inverted,
  output logic             link_pulse_rx,
  output logic             link_pulse_inverted,
  output logic             flp_page_valid,
  output logic      [15:0] flp_page
);
  logic [3:0] cnt_reg = 4'h0;
  initial begin
    {sq_pos_cross, sq_neg_cross, link_pulse_rx, link_pulse_inverted} = 4'h0;
    {flp_page_valid, flp_page} = 17'h00000;
  end
  // ==========
  // normal link pulse every 16 cycles; qualifier toggles between pulses
  assign eop_inverted = lp_inv;
  always @(posedge hclk) begin
    cnt_reg <= cnt_reg + 4'h1;
    link_pulse_rx <= lp_on && cnt_reg == 4'h0;
    link_pulse_inverted <= (cnt_reg == 4'h0) ? lp_inv : ~link_pulse_inverted;
  end
  // alternating crossings; a count of one is a lone noise spike
  task automatic packet(input int n);
    for (int k = 0; k < n; k++) begin
      @(posedge hclk);
      sq_pos_cross <= ~k[0];
      sq_neg_cross <= k[0];
    end
    @(posedge hclk);
    sq_pos_cross <= 1'b0;
    sq_neg_cross <= 1'b0;
  endtask
  task automatic flp(input logic [15:0] p);
    @(posedge hclk);
    flp_page <= p;
    flp_page_valid <= 1'b1;
    @(posedge hclk);
    flp_page <= ~p;
    flp_page_valid <= 1'b0;
  endtask
endmodule

// ===== bench/tlsa_top_assertions.sv
/*
  Checker bound to the top module.
  Assumes hclk and active-low hresetn.
*/
`timescale 1ns/1ps
module tlsa_checker (
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic tx_en,
  input wire logic repeater_mode,
  input wire logic rx_data_valid,
  input wire logic rx_end_of_packet,
  input wire logic squelch_reduced,
  input wire logic crs,
  input wire logic tx_drive_enable,
  input wire logic rx_enable,
  input wire logic col_enable,
  input wire logic link_pulse_tx,
  input wire logic link_ok,
  input wire logic mode_full_duplex
);
  default clocking cb @(posedge hclk); endclocking
  default disable iff (!hresetn);
  // ==========
  // receive side
  chk_eop_ends_valid: assert property (rx_end_of_packet |=> !rx_data_valid)
    else $error("valid after eop");
  chk_valid_drop_eop: assert property ($fell(rx_data_valid) |-> $past(rx_end_of_packet))
    else $error("valid ended without eop");
  chk_squelch_lowered: assert property ($rose(rx_data_valid) |-> squelch_reduced)
    else $error("squelch not reduced");
  chk_crs_tx_half: assert property (
    tx_drive_enable && !mode_full_duplex && !repeater_mode |-> crs)
    else $error("no crs on transmit");
  chk_crs_rx_only: assert property (crs && (mode_full_duplex || repeater_mode) |-> rx_data_valid)
    else $error("crs without receive");
  // ==========
  // link and transmit gating
  chk_rx_follows_link: assert property (rx_enable == link_ok)
    else $error("rx enable differs from link");
  chk_col_needs_link: assert property (col_enable |-> link_ok && !mode_full_duplex)
    else $error("collision enable wrong");
  chk_tx_gate_link: assert property (tx_drive_enable |-> tx_en && link_ok)
    else $error("transmit without enable or link");
  chk_pulse_width: assert property ($rose(link_pulse_tx) |=> link_pulse_tx ##1 !link_pulse_tx)
    else $error("pulse not two cycles");
  chk_pulse_idle: assert property ($rose(link_pulse_tx) |-> !$past(tx_en))
    else $error("pulse during transmit");
endmodule

bind tlsa_top tlsa_checker u_chk (.hclk(hclk), .hresetn(hresetn), .tx_en(tx_en),
  .repeater_mode(repeater_mode), .rx_data_valid(rx_data_valid),
  .rx_end_of_packet(rx_end_of_packet), .squelch_reduced(squelch_reduced), .crs(crs),
  .tx_drive_enable(tx_drive_enable), .rx_enable(rx_enable), .col_enable(col_enable),
  .link_pulse_tx(link_pulse_tx), .link_ok(link_ok), .mode_full_duplex(mode_full_duplex));

// ===== bench/tlsa_top_tb.sv
/*
  Self-checking bench with a partner model.
  Assumes the short counts set below.
*/
`timescale 1ns/1ps
module tlsa_top_tb;
  import tlsa_pkg::*;
  logic        hclk, hresetn, hsel, hwrite, tx_en, repeater_mode, lp_on, lp_inv;
  logic [31:0] haddr, hwdata, hrdata, q;
  logic [1:0]  htrans;
  logic [2:0]  hsize;
  logic [15:0] pg, ftw;
  logic        hreadyout, sqp, sqn, eopi, lprx, lpinv, pv, rdv, sqr, slc, crs, txde, rxe;
  logic        cole, lptx, pol, lok, fte, m100, mfd, hresp, eop;
  int          miscompares = 0;
  int          n_tests = 0;

  initial begin
    hclk = 1'b0;
    forever #25 hclk = ~hclk;
  end

  tlsa_top #(.JAB_CYCLES(40), .UNJAB_CYCLES(60), .LP_PERIOD_CYCLES(20), .LINK_LOSS_CYCLES(100))
    dut (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout), .hrdata(hrdata),
    .hreadyout(hreadyout), .hresp(hresp), .sq_pos_cross(sqp), .sq_neg_cross(sqn),
    .eop_inverted(eopi), .link_pulse_rx(lprx), .link_pulse_inverted(lpinv), .tx_en(tx_en),
    .repeater_mode(repeater_mode), .strap_rec_10m(1'b0), .strap_full_duplex(1'b1),
    .strap_an_disable(1'b0), .flp_page_valid(pv), .flp_page(pg), .rx_data_valid(rdv),
    .rx_end_of_packet(eop), .squelch_reduced(sqr), .squelch_long_cable(slc), .crs(crs),
    .tx_drive_enable(txde), .rx_enable(rxe), .col_enable(cole), .link_pulse_tx(lptx),
    .polarity_swap(pol), .link_ok(lok), .flp_tx_enable(fte), .flp_tx_word(ftw),
    .mode_100(m100), .mode_full_duplex(mfd));
  tlsa_partner lp (.hclk(hclk), .lp_on(lp_on), .lp_inv(lp_inv), .sq_pos_cross(sqp),
    .sq_neg_cross(sqn), .eop_inverted(eopi), .link_pulse_rx(lprx),
    .link_pulse_inverted(lpinv), .flp_page_valid(pv), .flp_page(pg));

  // ==========
  // shared tasks
  task automatic chk(input string nm, input logic [31:0] got, input logic [31:0] exp);
    n_tests++;
    if (got !== exp) begin
      miscompares++;
      $display("wrong value %s expected %h seen %h", nm, exp, got);
    end
  endtask
  task automatic cyc(input int n);
    repeat (n) @(posedge hclk);
  endtask
  // one single-word transfer; read data lands in q
  task automatic xf(input logic w, input logic [7:0] i, input logic [31:0] d);
    hsel <= 1'b1;
    haddr <= {22'h000000, i, 2'h0};
    htrans <= 2'h2;
    hsize <= 3'h2;
    hwrite <= w;
    @(posedge hclk);
    while (hreadyout !== 1'b1) @(posedge hclk);
    htrans <= 2'h0;
    hsel <= 1'b0;
    hwdata <= d;
    @(posedge hclk);
    while (hreadyout !== 1'b1) @(posedge hclk);
    q = hrdata;
  endtask
  task automatic rc(input logic [7:0] i, input logic [31:0] exp, input string nm);
    xf(1'b0, i, 32'h00000000);
    chk(nm, q, exp);
  endtask
  task automatic print_verdict();
    $display("comparisons %0d mismatches %0d", n_tests, miscompares);
    if (miscompares == 0 && n_tests > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask

  // ==========
  // scenarios
  task automatic t_regs();
    rc(IDX_TENBASE, 32'h00000000, "tenbase");
    xf(1'b1, IDX_TENBASE, 32'h0000FFFF);
    rc(IDX_TENBASE, 32'h00000481, "tenbase");
    chk("long_cable", 32'(slc), 32'h1);
    xf(1'b1, IDX_TENBASE, 32'h00000000);
    rc(8'h02, 32'h00000000, "unmapped");
    rc(IDX_ADVERT, 32'h000001E1, "advert");
    xf(1'b0, IDX_CONTROL, 32'h00000000);
    chk("an_enable", q & 32'h00001000, 32'h00001000);
    chk("flp_word", 32'(ftw), 32'h000001E1);
    chk("flp_on", 32'(fte), 32'h1);
  endtask
  task automatic t_an();
    lp.flp(16'h20C1);
    cyc(2);
    rc(IDX_STATUS, 32'h0000F83D, "status");
    rc(IDX_ANEXTRA, 32'h00000010, "an_extra");
    rc(IDX_PARTNER, 32'h000020C1, "partner");
    chk("hresp", 32'(hresp), 32'h0);
    chk("mode", 32'({m100, mfd}), 32'h2);
    chk("flp_on", 32'(fte), 32'h0);
  endtask
  task automatic t_mode();
    xf(1'b1, IDX_CONTROL, 32'h00002100);
    cyc(1);
    chk("mode", 32'({m100, mfd, fte}), 32'h6);
    xf(1'b1, IDX_CONTROL, 32'h00000000);
    tx_en <= 1'b1;
    cyc(2);
    chk("mode", 32'({m100, mfd}), 32'h0);
    chk("crs_tx", 32'({crs, cole}), 32'h3);
    chk("mac_col", 32'(tx_en & crs), 32'h1);
    repeater_mode <= 1'b1;
    cyc(2);
    chk("crs_rep", 32'(crs), 32'h0);
    repeater_mode <= 1'b0;
    tx_en <= 1'b0;
  endtask
  task automatic t_jab();
    tx_en <= 1'b1;
    cyc(30);
    chk("tx_drive", 32'(txde), 32'h1);
    cyc(20);
    chk("tx_drive", 32'(txde), 32'h0);
    for (int k = 0; k < 2; k++) begin
      tx_en <= 1'b0;
      cyc(40);
      tx_en <= 1'b1;
      cyc(1);
    end
    chk("tx_drive", 32'(txde), 32'h0);
    tx_en <= 1'b0;
    cyc(70);
    tx_en <= 1'b1;
    cyc(1);
    chk("tx_drive", 32'(txde), 32'h1);
    tx_en <= 1'b0;
    xf(1'b1, IDX_TENBASE, 32'h00000001);
    tx_en <= 1'b1;
    cyc(50);
    chk("tx_drive", 32'(txde), 32'h1);
    tx_en <= 1'b0;
    xf(1'b1, IDX_TENBASE, 32'h00000000);
  endtask
  task automatic t_sq();
    logic seen = 1'b0;
    fork
      lp.packet(12);
      begin
        cyc(8);
        chk("rx_valid", 32'({rdv, crs, sqr}), 32'h7);
      end
    join
    repeat (8) begin
      @(posedge hclk);
      seen = seen | eop;
    end
    chk("eop", 32'(seen), 32'h1);
    chk("rx_valid", 32'(rdv), 32'h0);
    seen = 1'b0;
    fork
      lp.packet(1);
      repeat (10) begin
        @(posedge hclk);
        seen = seen | rdv;
      end
    join
    chk("noise", 32'(seen), 32'h0);
  endtask
  task automatic t_pol();
    @(posedge hclk iff lprx);
    lp_inv <= 1'b1;
    repeat (6) @(posedge hclk iff lprx);
    cyc(2);
    chk("polarity", 32'(pol), 32'h0);
    @(posedge hclk iff lprx);
    cyc(2);
    chk("polarity", 32'(pol), 32'h1);
    lp_inv <= 1'b0;
    rc(IDX_PORTSTAT, 32'h00002000, "port_status");
  endtask
  task automatic t_link();
    int n = 0;
    @(posedge hclk iff lptx);
    @(posedge hclk iff !lptx);
    while (lptx !== 1'b1 && n < 100) begin
      @(posedge hclk);
      n++;
    end
    chk("pulse_gap", 32'(n), 32'd18);
    lp_on <= 1'b0;
    cyc(120);
    chk("link_lost", 32'({lok, rxe}), 32'h0);
    xf(1'b1, IDX_TENBASE, 32'h00000400);
    cyc(1);
    chk("link_forced", 32'(lok), 32'h1);
  endtask

  initial begin
    hresetn = 1'b0;
    hsel = 1'b0;
    haddr = 32'h00000000;
    htrans = 2'h0;
    hsize = 3'h0;
    hwrite = 1'b0;
    hwdata = 32'h00000000;
    tx_en = 1'b0;
    repeater_mode = 1'b0;
    lp_on = 1'b1;
    lp_inv = 1'b0;
    cyc(12);
    hresetn <= 1'b1;
    cyc(2);
    t_regs();
    t_an();
    t_mode();
    t_jab();
    t_sq();
    t_pol();
    t_link();
    print_verdict();
  end

  initial begin
    cyc(5000);
    miscompares++;
    print_verdict();
  end
endmodule

// ===== logic/tlsa_pkg.sv
/*
  Constants, register map and mode resolution for the 10Base-T link supervision
  and auto negotiation block.
  Assumes a 20 MHz system clock and a 32-bit AHB-Lite register bus.
*/
package tlsa_pkg;
  // ==========================================================================
  // clock and times
  localparam int CLK_HZ         = 20_000_000;
  localparam int CLK_NS         = 50;
  localparam int CYC_PER_MS     = CLK_HZ / 1000;
  localparam int SQ_WIN_NS      = 150;
  localparam int SQ_WIN_CYC     = SQ_WIN_NS / CLK_NS;
  localparam int EOP_IDLE_NS    = 200;
  localparam int EOP_IDLE_CYC   = EOP_IDLE_NS / CLK_NS;
  localparam int LP_WIDTH_NS    = 100;
  localparam int LP_WIDTH_CYC   = LP_WIDTH_NS / CLK_NS;
  localparam int JAB_MS         = 24;
  localparam int JAB_CYC        = JAB_MS * CYC_PER_MS;
  localparam int UNJAB_MS       = 408;
  localparam int UNJAB_CYC      = UNJAB_MS * CYC_PER_MS;
  localparam int LP_PERIOD_MS   = 16;
  localparam int LP_PERIOD_CYC  = LP_PERIOD_MS * CYC_PER_MS;
  localparam int LINK_LOSS_MS   = 100;
  localparam int LINK_LOSS_CYC  = LINK_LOSS_MS * CYC_PER_MS;
  localparam int POL_LP_COUNT   = 7;
  localparam int POL_EOP_COUNT  = 3;

  // ==========================================================================
  // register indices; byte address is four times the index
  localparam logic [7:0] IDX_CONTROL   = 8'h00;
  localparam logic [7:0] IDX_STATUS    = 8'h01;
  localparam logic [7:0] IDX_ADVERT    = 8'h04;
  localparam logic [7:0] IDX_PARTNER   = 8'h05;
  localparam logic [7:0] IDX_TENBASE   = 8'h10;
  localparam logic [7:0] IDX_PORTSTAT  = 8'h11;
  localparam logic [7:0] IDX_ANEXTRA   = 8'h17;

  // ==========================================================================
  // field positions
  localparam int CTL_SPEED_BIT      = 13;
  localparam int CTL_AN_EN_BIT      = 12;
  localparam int CTL_AN_RESTART_BIT = 9;
  localparam int CTL_DUPLEX_BIT     = 8;
  localparam int STS_AN_DONE_BIT    = 5;
  localparam int STS_RFAULT_BIT     = 4;
  localparam int STS_LINK_BIT       = 2;
  localparam logic [15:0] STS_FIXED = 16'hF809;
  localparam int ADV_RFAULT_BIT     = 13;
  localparam int ADV_100FD_BIT      = 8;
  localparam int ADV_100HD_BIT      = 7;
  localparam int ADV_10FD_BIT       = 6;
  localparam int ADV_10HD_BIT       = 5;
  localparam logic [4:0] ADV_SELECTOR = 5'h01;
  localparam int TB_LINKCHK_DIS_BIT = 10;
  localparam int TB_LONG_CABLE_BIT  = 7;
  localparam int TB_JAB_DIS_BIT     = 0;
  localparam logic [15:0] TB_WMASK  = 16'h0481;
  localparam logic [15:0] ADV_WMASK = 16'h21E0;
  localparam int PS_POL_REV_BIT     = 13;
  localparam int AX_AN_DONE_BIT     = 4;
  localparam logic [15:0] TB_RESET  = 16'h0000;

  typedef enum logic [1:0] {
    TLSA_10HD  = 2'b00,
    TLSA_10FD  = 2'b01,
    TLSA_100HD = 2'b10,
    TLSA_100FD = 2'b11
  } tlsa_mode_type;

  // highest common ability wins
  function automatic tlsa_mode_type tlsa_resolve(input logic [15:0] adv,
                                                input logic [15:0] lp);
    logic [15:0] common;
    common = adv & lp;
    if (common[ADV_100FD_BIT])      tlsa_resolve = TLSA_100FD;
    else if (common[ADV_100HD_BIT]) tlsa_resolve = TLSA_100HD;
    else if (common[ADV_10FD_BIT])  tlsa_resolve = TLSA_10FD;
    else                            tlsa_resolve = TLSA_10HD;
  endfunction
endpackage

// ===== logic/tlsa_top.sv
/*
  10Base-T link supervision and negotiation
  control for one port,
  registers behind an AHB-Lite slave.
  Assumes comparators, pulse receiver and
  burst engine outside, on hclk.
*/
// Our own choice: the AHB-Lite register port.
`timescale 1ns/1ps
// How it works
// R1: valid needs opposite then original crossing, each within 150 ns.
// R2: valid ends with end of packet after 200 ns silence.
// R3: squelch reduced while data valid.
// R4: long-cable bit lowers squelch.
// R5: half duplex crs on transmit or receive; full duplex or repeater mode receive only.
// R6: MAC ANDs transmit enable and crs for collision.
// R7: transmit enable over 24 ms disables transmitter while high.
// R8: transmitter returns after enable low about 408 ms.
// R9: config bit bypasses jabber.
// R10: no link pulses disables transmit, receive and collision.
// R11: idle link emits 100 ns pulse every 16 ms.
// R12: config bit disables link pulse checking.
// R13: seven inverted pulses or three inverted ends flip polarity.
// R14: negotiation runs only while enable bit set.
// R15: advertisement sent; partner abilities stored on success.
// R16: common abilities resolve mode, 100 full first.
// R17: negotiation off, speed and duplex bits pick mode.
// R18: status returns fixed ability ones.
// R19: status shows done, partner fault, link.
// R20: advertisement defaults to all, reducible by write or straps.
// R21: software trusts partner abilities only after done.
// R22: straps fill advertisement and control defaults.
// R23: early enable return restarts un-jab interval.
module tlsa_top
  import tlsa_pkg::*;
#(
  parameter int JAB_CYCLES       = tlsa_pkg::JAB_CYC,
  parameter int UNJAB_CYCLES     = tlsa_pkg::UNJAB_CYC,
  parameter int LP_PERIOD_CYCLES = tlsa_pkg::LP_PERIOD_CYC,
  parameter int LINK_LOSS_CYCLES = tlsa_pkg::LINK_LOSS_CYC
) (
  input  wire logic        hclk,
  input  wire logic        hresetn,
  input  wire logic        hsel,
  input  wire logic [31:0] haddr,
  input  wire logic [1:0]  htrans,
  input  wire logic        hwrite,
  input  wire logic [2:0]  hsize,
  input  wire logic [31:0] hwdata,
  input  wire logic        hready,
  output logic      [31:0] hrdata,
  output logic             hreadyout,
  output logic             hresp,
  input  wire logic        sq_pos_cross,
  input  wire logic        sq_neg_cross,
  input  wire logic        eop_inverted,
  input  wire logic        link_pulse_rx,
  input  wire logic        link_pulse_inverted,
  input  wire logic        tx_en,
  input  wire logic        repeater_mode,
  input  wire logic        strap_rec_10m,
  input  wire logic        strap_full_duplex,
  input  wire logic        strap_an_disable,
  input  wire logic        flp_page_valid,
  input  wire logic [15:0] flp_page,
  output logic             rx_data_valid,
  output logic             rx_end_of_packet,
  output logic             squelch_reduced,
  output logic             squelch_long_cable,
  output logic             crs,
  output logic             tx_drive_enable,
  output logic             rx_enable,
  output logic             col_enable,
  output logic             link_pulse_tx,
  output logic             polarity_swap,
  output logic             link_ok,
  output logic             flp_tx_enable,
  output logic      [15:0] flp_tx_word,
  output logic             mode_100,
  output logic             mode_full_duplex
);
  import tlsa_pkg::*;

  initial begin
    if (JAB_CYCLES < 1 || JAB_CYCLES >= (1 << 24) || UNJAB_CYCLES < 1 ||
        UNJAB_CYCLES >= (1 << 24) || LP_PERIOD_CYCLES <= LP_WIDTH_CYC ||
        LP_PERIOD_CYCLES >= (1 << 24) || LINK_LOSS_CYCLES < 1 ||
        LINK_LOSS_CYCLES >= (1 << 24)) begin
      $error("tlsa_top: count parameter out of range");
    end
  end

  localparam logic [23:0] JAB_LIM   = 24'(JAB_CYCLES);
  localparam logic [23:0] UNJAB_LIM = 24'(UNJAB_CYCLES);
  localparam logic [23:0] LP_LIM    = 24'(LP_PERIOD_CYCLES);
  localparam logic [23:0] LOSS_LIM  = 24'(LINK_LOSS_CYCLES);
  localparam logic [23:0] LP_HIGH   = 24'(LP_WIDTH_CYC);
  localparam logic [2:0]  SQ_LIM    = 3'(SQ_WIN_CYC);
  localparam logic [2:0]  EOP_LIM   = 3'(EOP_IDLE_CYC);
  localparam logic [2:0]  LPCNT_LIM = 3'(POL_LP_COUNT);
  localparam logic [1:0]  EPCNT_LIM = 2'(POL_EOP_COUNT);

  typedef enum logic [1:0] {
    SQ_IDLE      = 2'b00,
    SQ_WAIT_OPP  = 2'b01,
    SQ_WAIT_ORIG = 2'b10,
    SQ_VALID     = 2'b11
  } tlsa_sq_type;

  // ==========================================================================
  // registers and strap capture
  logic [15:0]   control_reg;
  logic [15:0]   advert_reg;
  logic [15:0]   partner_reg;
  logic [15:0]   tenbase_reg;
  logic          an_done_reg;
  logic          strap_done_reg;
  logic          pol_rev_reg;
  logic          an_enable;
  logic          wr_pending_reg;
  logic [7:0]    wr_idx_reg;
  logic          wr_ctl;
  logic          wr_adv;
  logic          wr_tb;
  tlsa_mode_type an_mode;

  assign an_enable = control_reg[CTL_AN_EN_BIT];
  assign wr_ctl    = wr_pending_reg && wr_idx_reg == IDX_CONTROL;
  assign wr_adv    = wr_pending_reg && wr_idx_reg == IDX_ADVERT;
  assign wr_tb     = wr_pending_reg && wr_idx_reg == IDX_TENBASE;

  // ==========================================================================
  // AHB-Lite slave, zero wait states
  logic addr_ok;
  logic [15:0] rd_value;

  assign hreadyout = 1'b1;
  assign hresp     = 1'b0;
  assign addr_ok   = hsel && htrans[1] && hready;

  always_comb begin
    rd_value = 16'h0000;
    unique case (haddr[9:2])
      IDX_CONTROL:  rd_value = control_reg;
      IDX_STATUS:   rd_value = STS_FIXED // R18
                               | (16'(an_done_reg) << STS_AN_DONE_BIT) // R19
                               | (16'(partner_reg[ADV_RFAULT_BIT]) << STS_RFAULT_BIT)
                               | (16'(link_ok) << STS_LINK_BIT);
      IDX_ADVERT:   rd_value = advert_reg;
      IDX_PARTNER:  rd_value = partner_reg;
      IDX_TENBASE:  rd_value = tenbase_reg;
      IDX_PORTSTAT: rd_value = 16'(pol_rev_reg) << PS_POL_REV_BIT; // R13
      IDX_ANEXTRA:  rd_value = 16'(an_done_reg) << AX_AN_DONE_BIT;
      default:      rd_value = 16'h0000;
    endcase
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      hrdata         <= 32'h0000_0000;
      wr_pending_reg <= 1'b0;
      wr_idx_reg     <= 8'h00;
    end else begin
      wr_pending_reg <= addr_ok && hwrite && hsize == 3'b010 && haddr[31:10] == '0;
      wr_idx_reg     <= haddr[9:2];
      if (addr_ok && !hwrite) begin
        hrdata <= (haddr[31:10] == '0) ? {16'h0000, rd_value} : 32'h0000_0000;
      end
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      strap_done_reg <= 1'b0;
      control_reg    <= 16'h0000;
      advert_reg     <= {11'h000, ADV_SELECTOR};
      tenbase_reg    <= TB_RESET;
    end else if (!strap_done_reg) begin
      strap_done_reg <= 1'b1;
      control_reg <= (16'(!strap_an_disable) << CTL_AN_EN_BIT) // R22
                     | (16'(!strap_rec_10m) << CTL_SPEED_BIT)
                     | (16'(strap_full_duplex) << CTL_DUPLEX_BIT);
      advert_reg <= {11'h000, ADV_SELECTOR} // R20
                    | (16'(!strap_rec_10m && strap_full_duplex) << ADV_100FD_BIT)
                    | (16'(!strap_rec_10m) << ADV_100HD_BIT)
                    | (16'(strap_full_duplex) << ADV_10FD_BIT)
                    | (16'h0001 << ADV_10HD_BIT);
    end else begin
      if (wr_ctl) begin
        control_reg <= hwdata[15:0];
      end else begin
        control_reg[CTL_AN_RESTART_BIT] <= 1'b0;
      end
      if (wr_adv) begin
        advert_reg <= (hwdata[15:0] & ADV_WMASK) | {11'h000, ADV_SELECTOR};
      end
      if (wr_tb) begin
        tenbase_reg <= hwdata[15:0] & TB_WMASK;
      end
    end
  end

  // ==========================================================================
  // auto negotiation control
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      an_done_reg <= 1'b0;
      partner_reg <= 16'h0000;
    end else if (!an_enable || (wr_ctl && hwdata[CTL_AN_RESTART_BIT])) begin
      an_done_reg <= 1'b0; // R14
    end else if (flp_page_valid && !an_done_reg) begin
      partner_reg <= flp_page; // R15
      an_done_reg <= 1'b1;
    end
  end

  assign flp_tx_enable = strap_done_reg && an_enable && !an_done_reg; // R14
  assign flp_tx_word   = advert_reg; // R15
  assign an_mode       = tlsa_resolve(advert_reg, partner_reg); // R16
  assign mode_100         = an_enable ? an_mode[1] : control_reg[CTL_SPEED_BIT]; // R17
  assign mode_full_duplex = an_enable ? an_mode[0] : control_reg[CTL_DUPLEX_BIT];

  // ==========================================================================
  // link integrity
  logic [23:0] loss_cnt_reg;
  logic        link_seen_reg;

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      loss_cnt_reg  <= 24'h000000;
      link_seen_reg <= 1'b0;
    end else if (link_pulse_rx || rx_data_valid) begin
      loss_cnt_reg  <= 24'h000000;
      link_seen_reg <= 1'b1;
    end else if (loss_cnt_reg >= LOSS_LIM - 24'h000001) begin
      link_seen_reg <= 1'b0;
    end else begin
      loss_cnt_reg <= loss_cnt_reg + 24'h000001;
    end
  end

  assign link_ok    = link_seen_reg || tenbase_reg[TB_LINKCHK_DIS_BIT]; // R12
  assign rx_enable  = link_ok; // R10
  assign col_enable = link_ok && !mode_full_duplex; // R10

  // ==========================================================================
  // smart squelch
  tlsa_sq_type sq_state_reg;
  logic        sq_first_pos_reg;
  logic [2:0]  sq_cnt_reg;
  logic        cross_orig;
  logic        cross_opp;

  assign cross_orig = sq_first_pos_reg ? sq_pos_cross : sq_neg_cross;
  assign cross_opp  = sq_first_pos_reg ? sq_neg_cross : sq_pos_cross;

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      sq_state_reg     <= SQ_IDLE;
      sq_first_pos_reg <= 1'b0;
      sq_cnt_reg       <= 3'h0;
    end else begin
      unique case (sq_state_reg)
        SQ_IDLE: begin
          sq_cnt_reg <= 3'h0;
          if (sq_pos_cross || sq_neg_cross) begin
            sq_first_pos_reg <= sq_pos_cross;
            sq_state_reg     <= SQ_WAIT_OPP;
          end
        end
        SQ_WAIT_OPP, SQ_WAIT_ORIG: begin
          if ((sq_state_reg == SQ_WAIT_OPP) ? cross_opp : cross_orig) begin
            sq_cnt_reg   <= 3'h0; // R1
            sq_state_reg <= (sq_state_reg == SQ_WAIT_OPP) ? SQ_WAIT_ORIG : SQ_VALID;
          end else if (sq_cnt_reg >= SQ_LIM - 3'h1) begin
            sq_state_reg <= SQ_IDLE; // R1
          end else begin
            sq_cnt_reg <= sq_cnt_reg + 3'h1;
          end
        end
        SQ_VALID: begin
          if (sq_pos_cross || sq_neg_cross) begin
            sq_cnt_reg <= 3'h0;
          end else if (sq_cnt_reg >= EOP_LIM) begin
            sq_state_reg <= SQ_IDLE; // R2
          end else begin
            sq_cnt_reg <= sq_cnt_reg + 3'h1;
          end
        end
      endcase
    end
  end

  assign rx_data_valid      = sq_state_reg == SQ_VALID; // R2
  assign rx_end_of_packet   = rx_data_valid && !(sq_pos_cross || sq_neg_cross)
                              && sq_cnt_reg >= EOP_LIM; // R2
  assign squelch_reduced    = rx_data_valid; // R3
  assign squelch_long_cable = tenbase_reg[TB_LONG_CABLE_BIT]; // R4

  // ==========================================================================
  // carrier sense
  assign crs = (rx_data_valid && link_ok) // R5
               || (!mode_full_duplex && !repeater_mode && tx_drive_enable);

  // ==========================================================================
  // jabber
  logic [23:0] jab_cnt_reg;
  logic        jabbed_reg;

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      jab_cnt_reg <= 24'h000000;
      jabbed_reg  <= 1'b0;
    end else if (tenbase_reg[TB_JAB_DIS_BIT]) begin
      jab_cnt_reg <= 24'h000000; // R9
      jabbed_reg  <= 1'b0;
    end else if (!jabbed_reg) begin
      if (!tx_en) begin
        jab_cnt_reg <= 24'h000000;
      end else if (jab_cnt_reg >= JAB_LIM - 24'h000001) begin
        jabbed_reg  <= 1'b1; // R7
        jab_cnt_reg <= 24'h000000;
      end else begin
        jab_cnt_reg <= jab_cnt_reg + 24'h000001;
      end
    end else if (tx_en) begin
      jab_cnt_reg <= 24'h000000; // R23
    end else if (jab_cnt_reg >= UNJAB_LIM - 24'h000001) begin
      jabbed_reg  <= 1'b0; // R8
      jab_cnt_reg <= 24'h000000;
    end else begin
      jab_cnt_reg <= jab_cnt_reg + 24'h000001;
    end
  end

  assign tx_drive_enable = tx_en && !jabbed_reg && link_ok; // R7 R10

  // ==========================================================================
  // link pulse generator
  logic [23:0] lp_cnt_reg;

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      lp_cnt_reg    <= 24'h000000;
      link_pulse_tx <= 1'b0;
    end else if ((tx_en || flp_tx_enable) && !link_pulse_tx) begin
      lp_cnt_reg    <= 24'h000000;
      link_pulse_tx <= 1'b0;
    end else begin
      // a started pulse always runs its full width
      lp_cnt_reg    <= (lp_cnt_reg >= LP_LIM - 24'h000001) ? 24'h000000
                       : lp_cnt_reg + 24'h000001; // R11
      link_pulse_tx <= lp_cnt_reg >= LP_LIM - LP_HIGH;
    end
  end

  // ==========================================================================
  // polarity detection
  logic [2:0] pol_lp_cnt_reg;
  logic [1:0] pol_eop_cnt_reg;

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      pol_lp_cnt_reg  <= 3'h0;
      pol_eop_cnt_reg <= 2'h0;
      pol_rev_reg     <= 1'b0;
    end else begin
      if (link_pulse_rx) begin
        pol_lp_cnt_reg <= link_pulse_inverted && pol_lp_cnt_reg < LPCNT_LIM
                          ? pol_lp_cnt_reg + 3'h1 : 3'h0;
      end
      if (rx_end_of_packet) begin
        pol_eop_cnt_reg <= eop_inverted && pol_eop_cnt_reg < EPCNT_LIM
                           ? pol_eop_cnt_reg + 2'h1 : 2'h0;
      end
      if ((link_pulse_rx && link_pulse_inverted && pol_lp_cnt_reg == LPCNT_LIM - 3'h1) ||
          (rx_end_of_packet && eop_inverted && pol_eop_cnt_reg == EPCNT_LIM - 2'h1)) begin
        pol_rev_reg     <= !pol_rev_reg; // R13
        pol_lp_cnt_reg  <= 3'h0;
        pol_eop_cnt_reg <= 2'h0;
      end
    end
  end

  assign polarity_swap = pol_rev_reg; // R13
endmodule
